// file: verilog/dccd_pkg.sv
package dccd_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CLOCK_SELECT_REG_OFS  = 8'h00;
  localparam logic [7:0] EVENT_FLAG_OFS        = 8'h04;
  localparam logic [7:0] IRQ_ENABLE_OFS        = 8'h08;
  localparam logic [7:0] HOLD_ENABLE_OFS       = 8'h0c;
  localparam logic [7:0] DIV_CLEAR_OFS         = 8'h10;
  localparam logic [7:0] DIV_STATUS_OFS        = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SYSCLK_SOURCE_SEL_BIT = 0;
  localparam int MAIN_OSC_STOP_BIT     = 1;
  localparam int LCD_DIV32_SEL_BIT     = 2;
  localparam int DIV1_PERIOD_SEL_BIT   = 3;
  localparam int EVF_DIV0_BIT          = 0;
  localparam int EVF_DIV1_BIT          = 4;
  localparam int DIV0_CLEAR_BIT        = 0;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int DIV_W      = 14;
  localparam int DIV_CLR_W  = 4;
  localparam int FLAG_W     = 8;
  localparam int CTRL_W     = 4;
  localparam int LCD_PRE_W  = 5;
  localparam logic [CTRL_W-1:0] CLOCK_SELECT_RST = 4'h0;
  localparam logic [FLAG_W-1:0] FLAG_RST         = 8'h00;
  localparam logic [FLAG_W-1:0] FLAG_IMPL_MASK   = 8'h11;
  localparam logic [1:0]        STATES_PER_CYCLE = 2'h3;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DCCD_IDLE = 2'b00,
    DCCD_RESP = 2'b01
  } dccd_bus_state_t;

endpackage

// file: verilog/dccd_top.sv
// Operation
// - Dual mode: select bit zero picks main (0) or sub (1) system clock.
// - Dual mode: stop bit one set halts the main oscillator, clear runs it.
// - Single mode ignores the select and stop bits; main oscillator always runs and clocks.
// - Display clock: sub clock in dual mode, main or main/32 in single.
// - One machine cycle is four consecutive system clock states.
// - Divider zero is a 14-bit up-counter on every system clock state, from main or sub.
// - Divider zero overflow sets flag 0, interrupts and releases hold if enabled.
// - Divider zero clear resets only the top four stages.
// - With 32768 Hz main, divider zero flag sets every 500 ms.
// - Divider one counts sub clocks in dual mode; overflow sets flag 4 likewise.
// - Period bit three picks divider one period: 500 ms at 0, 250 ms at 1.
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

module dccd_top
  import dccd_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Oscillator and strap pins
  input  wire logic        main_osc_clk,
  input  wire logic        sub_osc_clk,
  input  wire logic        dual_clock_mode,
  // Clock control and events
  output logic             main_osc_enable,
  output logic             sysclk_from_sub,
  output logic             sysclk_tick,
  output logic             machine_cycle,
  output logic             lcd_clk_tick,
  output logic             hold_release,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr[7:2] == ofs[7:2]);
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = hit(addr, CLOCK_SELECT_REG_OFS) | hit(addr, EVENT_FLAG_OFS) |
             hit(addr, IRQ_ENABLE_OFS) | hit(addr, HOLD_ENABLE_OFS) |
             hit(addr, DIV_CLEAR_OFS) | hit(addr, DIV_STATUS_OFS);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Index 0 main osc, 1 sub osc, 2 mode strap
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic [1:0] pin_last_q;
  logic       main_rise;
  logic       sub_rise;
  logic       dual_mode;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
      pin_last_q <= 2'h0;
    end else begin
      pin_meta_q <= {dual_clock_mode, sub_osc_clk, main_osc_clk};
      pin_sync_q <= pin_meta_q;
      pin_last_q <= pin_sync_q[1:0];
    end
  end

  assign main_rise = pin_sync_q[0] & ~pin_last_q[0];
  assign sub_rise  = pin_sync_q[1] & ~pin_last_q[1];
  assign dual_mode = pin_sync_q[2];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] clock_select_reg_q;
  logic [FLAG_W-1:0] event_flag_bits_q;
  logic [FLAG_W-1:0] irq_enable_bits_q;
  logic [FLAG_W-1:0] hold_release_enable_bits_q;
  logic [DIV_W-1:0]  div0_q;
  logic [DIV_W-1:0]  div1_q;
  logic              sysclk_source_sel;
  logic              main_osc_stop;
  logic              div1_period_sel;
  logic              main_running;
  logic              fosc_tick;

  assign sysclk_source_sel = dual_mode & clock_select_reg_q[SYSCLK_SOURCE_SEL_BIT];
  assign main_osc_stop     = dual_mode & clock_select_reg_q[MAIN_OSC_STOP_BIT];
  assign div1_period_sel   = clock_select_reg_q[DIV1_PERIOD_SEL_BIT];
  assign main_running      = ~main_osc_stop;
  assign fosc_tick = sysclk_source_sel ? sub_rise : (main_rise & main_running);

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire;
  logic        wr_lane0;
  logic [31:0] rd_word;
  dccd_bus_state_t wr_state_q;
  dccd_bus_state_t rd_state_q;

  // One write in flight: both halves held and no response pending
  assign wr_fire  = aw_held_q & w_held_q & (wr_state_q == DCCD_IDLE);
  assign wr_lane0 = wr_fire & w_strb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q   <= DCCD_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      case (wr_state_q)
        DCCD_IDLE: begin
          if (wr_fire) begin
            wr_state_q   <= DCCD_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
          end
        end
        DCCD_RESP: begin
          if (s_axi_bready) begin
            wr_state_q   <= DCCD_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state_q   <= DCCD_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    rd_word = 32'h0;
    if (hit(s_axi_araddr, CLOCK_SELECT_REG_OFS)) begin
      rd_word[CTRL_W-1:0] = clock_select_reg_q;
    end else if (hit(s_axi_araddr, EVENT_FLAG_OFS)) begin
      rd_word[FLAG_W-1:0] = event_flag_bits_q;
    end else if (hit(s_axi_araddr, IRQ_ENABLE_OFS)) begin
      rd_word[FLAG_W-1:0] = irq_enable_bits_q;
    end else if (hit(s_axi_araddr, HOLD_ENABLE_OFS)) begin
      rd_word[FLAG_W-1:0] = hold_release_enable_bits_q;
    end else if (hit(s_axi_araddr, DIV_STATUS_OFS)) begin
      rd_word = {2'h0, div1_q, 2'h0, div0_q};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q    <= DCCD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      case (rd_state_q)
        DCCD_IDLE: begin
          s_axi_arready <= ~(s_axi_arvalid & s_axi_arready);
          if (s_axi_arvalid && s_axi_arready) begin
            rd_state_q   <= DCCD_RESP;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
          end
        end
        DCCD_RESP: begin
          s_axi_arready <= 1'b0;
          if (s_axi_rready) begin
            rd_state_q   <= DCCD_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
        default: begin
          rd_state_q   <= DCCD_IDLE;
          s_axi_rvalid <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // order is software's duty
  // Stop and switch in one write are taken as written, not checked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_select_reg_q         <= CLOCK_SELECT_RST;
      irq_enable_bits_q          <= FLAG_RST;
      hold_release_enable_bits_q <= FLAG_RST;
    end else if (wr_lane0) begin
      if (hit(aw_addr_q, CLOCK_SELECT_REG_OFS)) begin
        clock_select_reg_q <= w_data_q[CTRL_W-1:0];
      end
      if (hit(aw_addr_q, IRQ_ENABLE_OFS)) begin
        irq_enable_bits_q <= w_data_q[FLAG_W-1:0] & FLAG_IMPL_MASK;
      end
      if (hit(aw_addr_q, HOLD_ENABLE_OFS)) begin
        hold_release_enable_bits_q <= w_data_q[FLAG_W-1:0] & FLAG_IMPL_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Dividers
  // ----------------------------------------------------------------
  logic div0_ovf;
  logic div1_ovf;
  logic div0_clr;

  assign div0_clr = wr_lane0 & hit(aw_addr_q, DIV_CLEAR_OFS) & w_data_q[DIV0_CLEAR_BIT];
  // 2^14 states of 32768 Hz is 500 ms
  assign div0_ovf = fosc_tick & (&div0_q);
  assign div1_ovf = dual_mode & sub_rise &
                    (div1_period_sel ? (&div1_q[DIV_W-2:0]) : (&div1_q));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div0_q <= '0;
    end else begin
      if (div0_clr) begin
        div0_q[DIV_W-1:DIV_W-DIV_CLR_W] <= '0;
        div0_q[DIV_W-DIV_CLR_W-1:0]     <= div0_q[DIV_W-DIV_CLR_W-1:0] +
                                           {{(DIV_W-DIV_CLR_W-1){1'b0}}, fosc_tick};
      end else if (fosc_tick) begin
        div0_q <= div0_q + 14'h0001;
      end
    end
  end

  // sub clock counts in dual mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div1_q <= '0;
    end else if (dual_mode && sub_rise) begin
      div1_q <= div1_q + 14'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_flag_bits_q <= FLAG_RST;
    end else begin
      event_flag_bits_q[EVF_DIV0_BIT] <= div0_ovf | (event_flag_bits_q[EVF_DIV0_BIT] &
        ~(wr_lane0 & hit(aw_addr_q, EVENT_FLAG_OFS) & w_data_q[EVF_DIV0_BIT]));
      event_flag_bits_q[EVF_DIV1_BIT] <= div1_ovf | (event_flag_bits_q[EVF_DIV1_BIT] &
        ~(wr_lane0 & hit(aw_addr_q, EVENT_FLAG_OFS) & w_data_q[EVF_DIV1_BIT]));
    end
  end

  // ----------------------------------------------------------------
  // Machine cycle and display clock
  // ----------------------------------------------------------------
  logic [1:0]           state_cnt_q;
  logic [LCD_PRE_W-1:0] lcd_pre_q;
  logic                 lcd_tick_d;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_cnt_q <= 2'h0;
    end else if (fosc_tick) begin
      state_cnt_q <= state_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lcd_pre_q <= '0;
    end else if (main_rise) begin
      lcd_pre_q <= lcd_pre_q + 5'h01;
    end
  end

  always_comb begin
    if (dual_mode) begin
      lcd_tick_d = sub_rise;
    end else if (clock_select_reg_q[LCD_DIV32_SEL_BIT]) begin
      lcd_tick_d = main_rise & (&lcd_pre_q);
    end else begin
      lcd_tick_d = main_rise;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_osc_enable <= 1'b1;
      sysclk_from_sub <= 1'b0;
      sysclk_tick     <= 1'b0;
      machine_cycle   <= 1'b0;
      lcd_clk_tick    <= 1'b0;
      hold_release    <= 1'b0;
      irq             <= 1'b0;
    end else begin
      main_osc_enable <= main_running;
      sysclk_from_sub <= sysclk_source_sel;
      sysclk_tick     <= fosc_tick;
      machine_cycle   <= fosc_tick & (state_cnt_q == STATES_PER_CYCLE);
      lcd_clk_tick    <= lcd_tick_d;
      hold_release    <= |(event_flag_bits_q & hold_release_enable_bits_q);
      irq             <= |(event_flag_bits_q & irq_enable_bits_q);
    end
  end

endmodule

`default_nettype wire

// file: bench/dccd_properties.sv
`timescale 1ns/1ps
`default_nettype none

module dccd_props
  import dccd_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Pins and events
  input wire logic sub_osc_clk,
  input wire logic dual_clock_mode,
  input wire logic main_osc_enable,
  input wire logic sysclk_from_sub,
  input wire logic sysclk_tick,
  input wire logic machine_cycle,
  input wire logic lcd_clk_tick
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Tick phase, so a missed or extra state shows at once
  logic [1:0] phase_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= 2'h0;
    end else if (sysclk_tick) begin
      phase_q <= phase_q + 2'h1;
    end
  end

  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence sub_rise_dual;
    dual_clock_mode [*6] ##0 $rose(sub_osc_clk);
  endsequence
  sequence sub_rise_sys;
    (dual_clock_mode && sysclk_from_sub) [*6] ##0 $rose(sub_osc_clk);
  endsequence

  a_mc_fourth: assert property (
    sysclk_tick |-> machine_cycle == (phase_q == 2'h3))
    else $error("machine cycle not on fourth state");
  a_mc_on_tick: assert property (machine_cycle |-> sysclk_tick)
    else $error("machine cycle without state");
  a_write_answer: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data missing");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken while answering");
  a_single_runs: assert property (
    (!dual_clock_mode) [*4] |=> main_osc_enable && !sysclk_from_sub)
    else $error("single mode lost main clock");
  a_lcd_sub: assert property (sub_rise_dual |-> ##[3:5] lcd_clk_tick)
    else $error("display tick missed sub edge");
  a_sub_state: assert property (sub_rise_sys |-> ##[3:5] sysclk_tick)
    else $error("system state missed sub edge");
endmodule

bind dccd_top dccd_props u_props (.*);

`default_nettype wire

// file: bench/dccd_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module dccd_cpu_model
  import dccd_pkg::*;
#(
  // Main oscillator settling, shortened from milliseconds
  parameter int SETTLE_CYC = 20
)
(
  // Clock
  input  wire logic        aclk,
  // Write address and data
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  // Write response
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read channels
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  logic [1:0] last_resp;

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
  end

  // Two settle edges let irq and pin outputs follow the write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic to_sub();
    wr(CLOCK_SELECT_REG_OFS, 32'h1);
    wr(CLOCK_SELECT_REG_OFS, 32'h3);
  endtask

  // restart, settle, then move the source
  task automatic to_main();
    wr(CLOCK_SELECT_REG_OFS, 32'h1);
    repeat (SETTLE_CYC) @(posedge aclk);
    wr(CLOCK_SELECT_REG_OFS, 32'h0);
  endtask
endmodule

`default_nettype wire

// file: bench/dual_clock_control_dividers_tb.sv
`timescale 1ns/1ps
`default_nettype none

module dual_clock_control_dividers_tb
  import dccd_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        main_osc_clk = 1'b0, sub_osc_clk = 1'b0, dual_clock_mode = 1'b1;
  logic        main_osc_enable, sysclk_from_sub, sysclk_tick, machine_cycle;
  logic        lcd_clk_tick, hold_release, irq;
  logic [7:0]  flags = 8'h0;
  logic [3:0]  clock_select_reg = 4'h0;
  int          err_total, compares, n_sys, n_mc, n_lcd, d0, d1, e_sys, n;

  dccd_top dut (.*);
  dccd_cpu_model u_cpu (.*);

  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    n_sys <= n_sys + int'(sysclk_tick === 1'b1);
    n_mc <= n_mc + int'(machine_cycle === 1'b1);
    n_lcd <= n_lcd + int'(lcd_clk_tick === 1'b1);
  end

  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    chk_data({31'h0, g}, {31'h0, e});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    u_cpu.rd(a, rd_d);
    chk_data(rd_d, e);
    chk_data(32'(u_cpu.last_resp), 32'(r));
  endtask

  // Pins idle during bus work so edge counts stay exact
  task automatic osc(input int k, input logic m, input logic s);
    int mm, se, o0, o1, l0;
    mm = m & (!dual_clock_mode | !clock_select_reg[1]);
    se = (dual_clock_mode & clock_select_reg[0]) ? s : mm;
    o0 = n_sys;
    l0 = n_lcd;
    o1 = d1;
    repeat (k) begin
      @(posedge aclk);
      main_osc_clk <= m & main_osc_enable;
      sub_osc_clk <= s;
      repeat (2) @(posedge aclk);
      {main_osc_clk, sub_osc_clk} <= 2'h0;
      @(posedge aclk);
    end
    repeat (8) @(posedge aclk);
    d0 += k * se;
    if (d0 >= 16384) flags[0] = 1'b1;
    d0 %= 16384;
    if (dual_clock_mode) d1 += k * s;
    if (clock_select_reg[3] ? (o1 >> 13) != (d1 >> 13) : d1 >= 16384) flags[4] = 1'b1;
    d1 %= 16384;
    e_sys += k * se;
    chk_data(32'(n_sys - o0), 32'(k * se));
    chk_data(32'(n_lcd - l0), 32'(dual_clock_mode ? k * s : clock_select_reg[2] ? k * mm / 32 : k * mm));
    rd_chk(DIV_STATUS_OFS, {2'h0, 14'(d1), 2'h0, 14'(d0)}, RESP_OKAY);
  endtask

  initial begin
    #1000000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(56720));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    for (int a = 0; a <= 24; a += 4) rd_chk(8'(a), 32'h0, a == 24 ? RESP_SLVERR : RESP_OKAY);
    u_cpu.wr(8'h18, 32'hff);
    chk_data(32'(u_cpu.last_resp), 32'(RESP_SLVERR));
    chk_bit(main_osc_enable, 1'b1);
    $display("test reset_map done");
    n = 4 * $urandom_range(2, 9);
    osc(n, 1'b1, 1'b1);
    u_cpu.to_sub();
    clock_select_reg = 4'h3;
    chk_bit(sysclk_from_sub, 1'b1);
    chk_bit(main_osc_enable, 1'b0);
    osc(n, 1'b1, 1'b1);
    u_cpu.to_main();
    clock_select_reg = 4'h0;
    chk_bit(sysclk_from_sub, 1'b0);
    chk_bit(main_osc_enable, 1'b1);
    $display("test dual done");
    dual_clock_mode <= 1'b0;
    u_cpu.wr(CLOCK_SELECT_REG_OFS, 32'h3);
    clock_select_reg = 4'h3;
    chk_bit(sysclk_from_sub, 1'b0);
    chk_bit(main_osc_enable, 1'b1);
    osc(n, 1'b1, 1'b1);
    u_cpu.wr(CLOCK_SELECT_REG_OFS, 32'h4);
    clock_select_reg = 4'h4;
    // Enough states that stage ten, the lowest of the top four, holds a one before the clear
    osc(1088, 1'b1, 1'b0);
    u_cpu.wr(DIV_CLEAR_OFS, 32'h1);
    d0 &= 32'h3ff;
    rd_chk(DIV_STATUS_OFS, {2'h0, 14'(d1), 2'h0, 14'(d0)}, RESP_OKAY);
    $display("test single done");
    dual_clock_mode <= 1'b1;
    u_cpu.wr(CLOCK_SELECT_REG_OFS, 32'h8);
    clock_select_reg = 4'h8;
    u_cpu.wr(IRQ_ENABLE_OFS, 32'h11);
    u_cpu.wr(HOLD_ENABLE_OFS, 32'h10);
    // Half a long period: only the short divider one period may flag
    osc(8192, 1'b1, 1'b1);
    rd_chk(EVENT_FLAG_OFS, 32'(flags), RESP_OKAY);
    osc(8192, 1'b1, 1'b1);
    rd_chk(EVENT_FLAG_OFS, 32'(flags), RESP_OKAY);
    chk_bit(irq, 1'b1);
    chk_bit(hold_release, 1'b1);
    u_cpu.wr(EVENT_FLAG_OFS, 32'h1);
    rd_chk(EVENT_FLAG_OFS, 32'h10, RESP_OKAY);
    chk_bit(irq, 1'b1);
    u_cpu.wr(IRQ_ENABLE_OFS, 32'h1);
    chk_bit(irq, 1'b0);
    u_cpu.wr(EVENT_FLAG_OFS, 32'h10);
    chk_bit(hold_release, 1'b0);
    chk_data(32'(n_mc), 32'(e_sys / 4));
    $display("test events done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
